// *** src/csl_regs.sv ***
// Notes on behaviour
// R01 - Sense ranges ch2..4 at bits 13:8
// R02 - Sense code: unipolar, bipolar full, half, reserved
// R03 - Bus ranges ch1..4 at bits 7:0
// R04 - Bus code: unipolar, bipolar full, half, reserved
// R05 - Latched control shows settings before last snapshot
// R06 - Pending writes wait for a snapshot
// R07 - Latched control valid 1 ms after snapshot
// R08 - Latched control invalid until first snapshot
// R09 - Modes 0..3 adaptive at four rates
// R10 - Modes 4..7 continuous at four rates
// R11 - Modes 8..b single, single8, fast, burst
// R12 - Modes c..e reserved, f is sleep
// R13 - Exactly one sampling mode at a time
// R14 - Pin b selector at bits 11:10
// R15 - Pin a selector at bits 9:8
// R16 - High slow pin forces eight samples/second
// R17 - General purpose pin data in separate register
// R18 - Latched: mode 15:12, mask 7:4, low zero
// R19 - Mask bit set skips that channel
// R20 - Rate change waits for conversion cycle end
// R21 - Snapshot latches active before loading pending
// R22 - Writes to image registers are ignored
`timescale 1ns/1ps
module csl_regs #(
    parameter int VALID_CYCLES = csl_pkg::VALID_CYCLES
) (
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Register port.
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_rd,
    input  wire logic        reg_wr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    output logic             reg_ack,
    // Pending settings and snapshot command.
    input  wire logic [15:0] pending_ctrl,
    input  wire logic [15:0] pending_range,
    input  wire logic        snapshot,
    // Conversion engine handshake.
    input  wire logic        cycle_done,
    input  wire logic        alert_a,
    input  wire logic        alert_b,
    // Multipurpose pins.
    input  wire logic        pin_a_i,
    output logic             pin_a_o,
    output logic             pin_a_oe,
    input  wire logic        pin_b_i,
    output logic             pin_b_o,
    output logic             pin_b_oe,
    // Settings in force.
    output logic [15:0]      active_ctrl,
    output logic [15:0]      active_range,
    output logic [15:0]      latched_ctrl,
    output logic             latched_valid,
    output logic [3:0]       channel_enable,
    output logic [1:0]       rate_sel,
    output logic [7:0]       mode_flags,
    output logic [3:0]       sense_bipolar,
    output logic [3:0]       sense_half,
    output logic [3:0]       bus_bipolar,
    output logic [3:0]       bus_half,
    output logic             range_reserved
);
    csl_pkg::csl_state_e state;
    csl_pkg::csl_state_e next_state;
    logic [15:0] staged_ctrl;
    logic [15:0] staged_range;
    logic [13:0] valid_cnt;
    logic        valid_run;
    logic        seen_snap;
    logic [1:0]  gp_out;
    logic [1:0]  pin_lvl;
    logic [1:0]  pin_a_fn;
    logic [1:0]  pin_b_fn;
    logic        slow_req;
    logic        rate_change;
    logic [3:0]  rsv_s;
    logic [3:0]  rsv_b;

    initial
    begin
        // One cycle would let validity rise inside the two-cycle drop window.
        if (VALID_CYCLES < 2 || VALID_CYCLES > 16383)
            $error("VALID_CYCLES must lie between 2 and the 14-bit counter limit.");
    end

    assign pin_b_fn = active_ctrl[csl_pkg::PIN_B_LSB +: 2]; // R14
    assign pin_a_fn = active_ctrl[csl_pkg::PIN_A_LSB +: 2]; // R15
    // A new mode changes the rate; sleep has no cycle in flight to wait for.
    assign rate_change = (staged_ctrl[csl_pkg::MODE_LSB +: 4]
                          != active_ctrl[csl_pkg::MODE_LSB +: 4])
                      && (active_ctrl[csl_pkg::MODE_LSB +: 4] != csl_pkg::MODE_SLEEP);

    // Load sequencing for the active images.
    always_comb
    begin
        next_state = state;
        case (state)
            csl_pkg::ST_IDLE: if (snapshot) next_state = csl_pkg::ST_WAIT;
            // A new command in the wait restarts it, so its settings are never lost.
            csl_pkg::ST_WAIT:
                if (!snapshot && (!rate_change || cycle_done))
                    next_state = csl_pkg::ST_IDLE;
            default:          next_state = csl_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            state <= csl_pkg::ST_IDLE;
        else
            state <= next_state;
    end

    // Pending settings are captured at the command; they stay out of force till then.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            staged_ctrl  <= csl_pkg::CTRL_RESET;
            staged_range <= csl_pkg::RANGE_RESET;
        end
        else if (snapshot)
        begin
            staged_ctrl  <= pending_ctrl & csl_pkg::CTRL_IMPL; // R06
            staged_range <= pending_range;
        end
    end

    // Active images change only on leaving the wait state; writes never reach them.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            active_ctrl  <= csl_pkg::CTRL_RESET;
            active_range <= csl_pkg::RANGE_RESET;
        end
        else if (state == csl_pkg::ST_WAIT && !snapshot && (!rate_change || cycle_done))
        begin
            active_ctrl  <= staged_ctrl;  // R20
            active_range <= staged_range; // R22
        end
    end

    // The copy takes the old active image, so it matches the results just frozen.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            latched_ctrl <= csl_pkg::CTRL_RESET & csl_pkg::CTRL_IMPL;
        else if (snapshot)
            latched_ctrl <= active_ctrl & csl_pkg::CTRL_IMPL; // R05 R21
    end

    // Validity timer; a fresh snapshot restarts the wait for new results.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            valid_cnt     <= '0;
            valid_run     <= 1'b0;
            latched_valid <= 1'b0; // R08
            seen_snap     <= 1'b0;
        end
        else if (snapshot)
        begin
            valid_cnt     <= '0;
            valid_run     <= 1'b1;
            latched_valid <= 1'b0;
            seen_snap     <= 1'b1;
        end
        else if (valid_run)
        begin
            if (valid_cnt == 14'(VALID_CYCLES - 1))
            begin
                valid_run     <= 1'b0;
                latched_valid <= 1'b1; // R07
            end
            else
                valid_cnt <= valid_cnt + 14'h1;
        end
    end

    // General purpose output data; input mode bits read the pin instead.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            gp_out <= 2'h0;
        else if (reg_wr && reg_addr == csl_pkg::GPIO_DATA_OFS)
            gp_out <= reg_wdata[1:0]; // R17
    end

    csl_pin_sync #(.W(2)) u_sync (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .pin_raw   ({pin_b_i, pin_a_i}),
        .pin_level (pin_lvl)
    );

    assign slow_req = (pin_a_fn == csl_pkg::PIN_SLOW && pin_lvl[0])
                   || (pin_b_fn == csl_pkg::PIN_SLOW && pin_lvl[1]); // R16

    // Pin drivers: open-drain alert low when asserted, push data in output mode.
    always_comb
    begin
        pin_a_o  = (pin_a_fn == csl_pkg::PIN_GP_OUT) ? gp_out[0] : 1'b0;
        pin_a_oe = (pin_a_fn == csl_pkg::PIN_GP_OUT)
                || (pin_a_fn == csl_pkg::PIN_ALERT && alert_a);
        pin_b_o  = (pin_b_fn == csl_pkg::PIN_GP_OUT) ? gp_out[1] : 1'b0;
        pin_b_oe = (pin_b_fn == csl_pkg::PIN_GP_OUT)
                || (pin_b_fn == csl_pkg::PIN_ALERT && alert_b);
    end

    csl_mode_decode u_mode (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .mode          (active_ctrl[csl_pkg::MODE_LSB +: 4]),
        .slow_req      (slow_req),
        .md_adaptive   (mode_flags[0]),
        .md_continuous (mode_flags[1]),
        .md_single     (mode_flags[2]),
        .md_single8    (mode_flags[3]),
        .md_fast       (mode_flags[4]),
        .md_burst      (mode_flags[5]),
        .md_sleep      (mode_flags[6]),
        .md_reserved   (mode_flags[7]),
        .rate_sel      (rate_sel)
    );

    // Per channel range decode; channel 1 sits in the top pair of each byte.
    for (genvar i = 0; i < 4; i++)
    begin : g_ch
        localparam int SL = csl_pkg::SENSE_CH1_LSB - 2 * i;
        localparam int BL = csl_pkg::BUS_CH1_LSB - 2 * i;
        assign sense_bipolar[i] = active_range[SL +: 2] == csl_pkg::RANGE_BI_FULL  // R01
                               || active_range[SL +: 2] == csl_pkg::RANGE_BI_HALF; // R02
        assign sense_half[i]    = active_range[SL +: 2] == csl_pkg::RANGE_BI_HALF;
        assign rsv_s[i]         = active_range[SL +: 2] == csl_pkg::RANGE_RSVD;
        assign bus_bipolar[i]   = active_range[BL +: 2] == csl_pkg::RANGE_BI_FULL  // R03
                               || active_range[BL +: 2] == csl_pkg::RANGE_BI_HALF; // R04
        assign bus_half[i]      = active_range[BL +: 2] == csl_pkg::RANGE_BI_HALF;
        assign rsv_b[i]         = active_range[BL +: 2] == csl_pkg::RANGE_RSVD;
        // Mask bit 7 is channel 1, bit 4 channel 4.
        assign channel_enable[i] = !active_ctrl[csl_pkg::CH_OFF_LSB + 3 - i]; // R19
    end
    assign range_reserved = |{rsv_s, rsv_b};

    // Register reads answer one cycle later; unmapped offsets read zero.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata <= 16'h0000;
            reg_ack   <= 1'b0;
        end
        else
        begin
            reg_ack <= reg_rd || reg_wr;
            if (reg_rd)
            begin
                case (reg_addr)
                    csl_pkg::ACT_CTRL_OFS:  reg_rdata <= active_ctrl;
                    csl_pkg::ACT_RANGE_OFS: reg_rdata <= active_range;
                    csl_pkg::LAT_CTRL_OFS:  reg_rdata <= latched_ctrl; // R18
                    csl_pkg::GPIO_DATA_OFS: reg_rdata <= {14'h0000,
                        pin_b_fn == csl_pkg::PIN_GP_IN ? pin_lvl[1] : gp_out[1],
                        pin_a_fn == csl_pkg::PIN_GP_IN ? pin_lvl[0] : gp_out[0]};
                    default:                reg_rdata <= 16'h0000;
                endcase
            end
        end
    end

    sequence snap_s;
        snapshot;
    endsequence
    sequence wait_end_s;
        state == csl_pkg::ST_WAIT && !snapshot && (!rate_change || cycle_done);
    endsequence

    snap_latch_a: assert property (@(posedge clk_sys) disable iff (rst) // R21
        snap_s |=> latched_ctrl == ($past(active_ctrl) & csl_pkg::CTRL_IMPL))
        else $error("Latched control did not take the old active image.");
    latch_hold_a: assert property (@(posedge clk_sys) disable iff (rst) // R05
        !snapshot |=> $stable(latched_ctrl))
        else $error("Latched control changed without a snapshot.");
    low_zero_a: assert property (@(posedge clk_sys) disable iff (rst) // R18
        latched_ctrl[3:0] == 4'h0)
        else $error("Latched control low bits not zero.");
    pend_hold_a: assert property (@(posedge clk_sys) disable iff (rst) // R06
        state == csl_pkg::ST_IDLE |=> $stable(active_ctrl) && $stable(active_range))
        else $error("Active image changed without a snapshot.");
    rate_wait_a: assert property (@(posedge clk_sys) disable iff (rst) // R20
        state == csl_pkg::ST_WAIT && rate_change && !cycle_done |=> $stable(active_ctrl))
        else $error("Rate change took effect before cycle end.");
    load_new_a: assert property (@(posedge clk_sys) disable iff (rst) // R20
        wait_end_s |=> active_ctrl == $past(staged_ctrl) && state == csl_pkg::ST_IDLE)
        else $error("Staged settings not loaded at cycle end.");
    valid_drop_a: assert property (@(posedge clk_sys) disable iff (rst) // R07
        snap_s |=> !latched_valid [*2])
        else $error("Latched control valid too soon after snapshot.");
    valid_time_a: assert property (@(posedge clk_sys) disable iff (rst) // R07
        $rose(latched_valid) |-> $past(valid_cnt) == 14'(VALID_CYCLES - 1))
        else $error("Latched control valid at the wrong time.");
    first_snap_a: assert property (@(posedge clk_sys) disable iff (rst) // R08
        !seen_snap |-> !latched_valid)
        else $error("Latched control valid before any snapshot.");
    write_ign_a: assert property (@(posedge clk_sys) disable iff (rst) // R22
        reg_wr && state == csl_pkg::ST_IDLE && !snapshot |=> $stable(latched_ctrl)
        && $stable(active_ctrl))
        else $error("Register write altered an image register.");
endmodule

// *** src/csl_pkg.sv ***
package csl_pkg;
    // Register offsets on the device register port.
    localparam logic [7:0] GPIO_DATA_OFS  = 8'h1c;
    localparam logic [7:0] ACT_CTRL_OFS   = 8'h21;
    localparam logic [7:0] ACT_RANGE_OFS  = 8'h22;
    localparam logic [7:0] LAT_CTRL_OFS   = 8'h23;
    // Control image layout and reset value.
    localparam int         MODE_LSB       = 12;
    localparam int         PIN_B_LSB      = 10;
    localparam int         PIN_A_LSB      = 8;
    localparam int         CH_OFF_LSB     = 4;
    localparam logic [15:0] CTRL_RESET    = 16'h0700;
    localparam logic [15:0] CTRL_IMPL     = 16'hfff0;
    localparam logic [15:0] RANGE_RESET   = 16'h0000;
    // Range fields: channel 1 sense at 15:14, bus at 7:6, two bits per channel.
    localparam int         SENSE_CH1_LSB  = 14;
    localparam int         BUS_CH1_LSB    = 6;
    localparam logic [1:0] RANGE_UNI      = 2'h0;
    localparam logic [1:0] RANGE_BI_FULL  = 2'h1;
    localparam logic [1:0] RANGE_BI_HALF  = 2'h2;
    localparam logic [1:0] RANGE_RSVD     = 2'h3;
    // Pin function codes.
    localparam logic [1:0] PIN_ALERT      = 2'h0;
    localparam logic [1:0] PIN_GP_IN      = 2'h1;
    localparam logic [1:0] PIN_GP_OUT     = 2'h2;
    localparam logic [1:0] PIN_SLOW       = 2'h3;
    // Sampling mode codes.
    localparam logic [3:0] MODE_ADAPT_LO  = 4'h0;
    localparam logic [3:0] MODE_CONT_LO   = 4'h4;
    localparam logic [3:0] MODE_SINGLE    = 4'h8;
    localparam logic [3:0] MODE_SINGLE8   = 4'h9;
    localparam logic [3:0] MODE_FAST      = 4'ha;
    localparam logic [3:0] MODE_BURST     = 4'hb;
    localparam logic [3:0] MODE_SLEEP     = 4'hf;
    // Rate selects: 1024, 256, 64 and 8 samples per second.
    localparam logic [1:0] RATE_8SPS      = 2'h3;
    // Result validity delay after a snapshot.
    localparam int         CLK_PERIOD_NS  = 100;
    localparam int         VALID_TIME_MS  = 1;
    localparam int         VALID_CYCLES   = (VALID_TIME_MS * 1000000 + CLK_PERIOD_NS - 1)
                                            / CLK_PERIOD_NS;
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_WAIT = 1'b1
    } csl_state_e;
endpackage

// *** src/csl_pin_sync.sv ***
`timescale 1ns/1ps
module csl_pin_sync #(
    parameter int W = 2
) (
    // Clock and reset.
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // Raw pins and filtered levels.
    input  wire logic [W-1:0] pin_raw,
    output logic      [W-1:0] pin_level
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    initial
    begin
        if (W < 1) $error("csl_pin_sync needs at least one pin.");
    end

    // Three stages; a level is accepted only once stages two and three agree.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end
        else
        begin
            s1 <= pin_raw;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Per pin filter, so that a glitch on one pin never holds the others.
    for (genvar i = 0; i < W; i++)
    begin : g_flt
        always_ff @(posedge clk_sys or posedge rst)
        begin
            if (rst)
                pin_level[i] <= 1'b0;
            else if (s2[i] == s3[i])
                pin_level[i] <= s3[i];
        end
    end
endmodule

// *** src/csl_mode_decode.sv ***
`timescale 1ns/1ps
module csl_mode_decode (
    // Clock and reset, used by the checks only.
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Active mode and slow request.
    input  wire logic [3:0] mode,
    input  wire logic       slow_req,
    // Decoded mode, exactly one flag high.
    output logic            md_adaptive,
    output logic            md_continuous,
    output logic            md_single,
    output logic            md_single8,
    output logic            md_fast,
    output logic            md_burst,
    output logic            md_sleep,
    output logic            md_reserved,
    // Effective rate select.
    output logic [1:0]      rate_sel
);
    // Mode field decode; the top two bits pick the family.
    always_comb
    begin
        md_adaptive   = (mode[3:2] == csl_pkg::MODE_ADAPT_LO[3:2]); // R09
        md_continuous = (mode[3:2] == csl_pkg::MODE_CONT_LO[3:2]);  // R10
        md_single     = (mode == csl_pkg::MODE_SINGLE);            // R11
        md_single8    = (mode == csl_pkg::MODE_SINGLE8);
        md_fast       = (mode == csl_pkg::MODE_FAST);
        md_burst      = (mode == csl_pkg::MODE_BURST);
        md_sleep      = (mode == csl_pkg::MODE_SLEEP);             // R12
        md_reserved   = (mode[3:2] == csl_pkg::MODE_SLEEP[3:2]) && !md_sleep; // R12
    end

    // The slow pin wins over the programmed rate of the periodic modes.
    assign rate_sel = slow_req ? csl_pkg::RATE_8SPS : mode[1:0]; // R16

    one_mode_a: assert property (@(posedge clk_sys) disable iff (rst) // R13
        $onehot({md_adaptive, md_continuous, md_single, md_single8, md_fast,
                 md_burst, md_sleep, md_reserved}))
        else $error("Mode decode is not one-hot.");
    slow_rate_a: assert property (@(posedge clk_sys) disable iff (rst) // R16
        slow_req |-> rate_sel == csl_pkg::RATE_8SPS)
        else $error("Slow pin did not force eight samples per second.");
endmodule

// *** tb/csl_regs_bench.sv ***
`timescale 1ns/1ps
module csl_regs_bench;
    // Short validity count keeps the run brief; every validity timing expectation derives from it.
    localparam int VC = 20;
    logic        clk_sys, rst, reg_rd, reg_wr, snapshot, cycle_done;
    logic        alert_a, alert_b, pin_a_i, pin_b_i, reg_ack, latched_valid;
    logic        pin_a_o, pin_a_oe, pin_b_o, pin_b_oe, range_reserved;
    logic [7:0]  reg_addr, mode_flags;
    logic [15:0] reg_wdata, pending_ctrl, pending_range, reg_rdata, rd;
    logic [15:0] active_ctrl, active_range, latched_ctrl;
    logic [3:0]  channel_enable, sense_bipolar, sense_half, bus_bipolar, bus_half;
    logic [1:0]  rate_sel;
    int          num_errors = 0;
    int          samples_checked = 0;

    csl_regs #(.VALID_CYCLES(VC)) dut (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .pending_ctrl(pending_ctrl), .pending_range(pending_range), .snapshot(snapshot),
        .cycle_done(cycle_done), .alert_a(alert_a), .alert_b(alert_b),
        .pin_a_i(pin_a_i), .pin_a_o(pin_a_o), .pin_a_oe(pin_a_oe), .pin_b_i(pin_b_i),
        .pin_b_o(pin_b_o), .pin_b_oe(pin_b_oe), .active_ctrl(active_ctrl),
        .active_range(active_range), .latched_ctrl(latched_ctrl),
        .latched_valid(latched_valid), .channel_enable(channel_enable),
        .rate_sel(rate_sel), .mode_flags(mode_flags), .sense_bipolar(sense_bipolar),
        .sense_half(sense_half), .bus_bipolar(bus_bipolar), .bus_half(bus_half),
        .range_reserved(range_reserved));

    // Free-running system clock, 100 ns period.
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Single exit point so a hang and a normal end report alike.
    task automatic print_verdict();
        $display("checks made %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Inputs always move 1 ns after the rising edge.
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge clk_sys);
            #1;
        end
    endtask

    task automatic reg_access(input logic wr, input logic [7:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_rd = ~wr;
        reg_wr = wr;
        tick(1);
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        // One idle edge after the answer keeps strobes of back to back calls apart.
        for (int i = 0; i < 4; i++)
        begin
            if (reg_ack === 1'b1)
            begin
                rd = reg_rdata;
                tick(1);
                return;
            end
            tick(1);
        end
        num_errors++;
        print_verdict();
    endtask

    task automatic snap();
        snapshot = 1'b1;
        tick(1);
        snapshot = 1'b0;
    endtask

    // Bounded wait for the active image to take an expected value.
    task automatic wait_active(input logic [15:0] exp);
        for (int i = 0; i < 6 && (active_ctrl & csl_pkg::CTRL_IMPL) !== exp; i++)
            tick(1);
        chk16(active_ctrl & csl_pkg::CTRL_IMPL, exp);
    endtask

    task automatic t_reset();
        chk16({15'h0000, latched_valid}, 16'h0000);
        reg_access(1'b0, csl_pkg::ACT_CTRL_OFS, 16'h0000);
        chk16(rd, csl_pkg::CTRL_RESET);
        reg_access(1'b0, csl_pkg::ACT_RANGE_OFS, 16'h0000);
        chk16(rd, 16'h0000);
        reg_access(1'b0, csl_pkg::LAT_CTRL_OFS, 16'h0000);
        chk16(rd, csl_pkg::CTRL_RESET);
        reg_access(1'b0, 8'h40, 16'h0000);
        chk16(rd, 16'h0000);
        chk16({14'h0000, pin_a_oe, pin_b_oe}, 16'h0000);
        $display("test reset finished");
    endtask

    task automatic t_ro_writes();
        reg_access(1'b1, csl_pkg::ACT_CTRL_OFS, 16'hffff);
        reg_access(1'b1, csl_pkg::ACT_RANGE_OFS, 16'hffff);
        reg_access(1'b1, csl_pkg::LAT_CTRL_OFS, 16'hffff);
        reg_access(1'b0, csl_pkg::ACT_CTRL_OFS, 16'h0000);
        chk16(rd, csl_pkg::CTRL_RESET);
        reg_access(1'b0, csl_pkg::ACT_RANGE_OFS, 16'h0000);
        chk16(rd, 16'h0000);
        reg_access(1'b0, csl_pkg::LAT_CTRL_OFS, 16'h0000);
        chk16(rd, csl_pkg::CTRL_RESET);
        $display("test read-only writes finished");
    endtask

    // Same mode, new pins, mask and ranges covering every range code.
    task automatic t_snapshot();
        logic [3:0] sb, sh, bb, bh;
        logic [1:0] s, b;
        pending_ctrl = 16'h0e5a;
        pending_range = 16'h1be4;
        tick(3);
        chk16(active_ctrl, csl_pkg::CTRL_RESET);
        snap();
        chk16(latched_ctrl, csl_pkg::CTRL_RESET);
        chk16(active_ctrl, csl_pkg::CTRL_RESET);
        tick(1);
        chk16(active_ctrl & csl_pkg::CTRL_IMPL, 16'h0e50);
        chk16({12'h000, channel_enable}, 16'h0005);
        reg_access(1'b0, csl_pkg::ACT_RANGE_OFS, 16'h0000);
        chk16(rd, 16'h1be4);
        for (int f = 0; f < 4; f++)
        begin
            s = pending_range[15 - 2 * f -: 2];
            b = pending_range[7 - 2 * f -: 2];
            sb[f] = (s == 2'h1) || (s == 2'h2);
            sh[f] = (s == 2'h2);
            bb[f] = (b == 2'h1) || (b == 2'h2);
            bh[f] = (b == 2'h2);
        end
        chk16({sense_bipolar, sense_half, bus_bipolar, bus_half}, {sb, sh, bb, bh});
        chk16({15'h0000, range_reserved}, 16'h0001);
        tick(VC - 4);
        chk16({15'h0000, latched_valid}, 16'h0000);
        tick(1);
        chk16({15'h0000, latched_valid}, 16'h0001);
        $display("test snapshot finished");
    endtask

    // Walk every mode code; a mode change must wait for the cycle end.
    task automatic t_modes();
        logic [15:0] prev, exp;
        logic [7:0]  fl;
        pending_range = 16'h6a96;
        for (int c = 0; c < 16; c++)
        begin
            prev = active_ctrl & csl_pkg::CTRL_IMPL;
            exp = {c[3:0], 4'h5, 8'h00};
            pending_ctrl = exp;
            snap();
            tick(2);
            if (prev[15:12] != c[3:0] && prev[15:12] != csl_pkg::MODE_SLEEP)
                chk16(active_ctrl & csl_pkg::CTRL_IMPL, prev);
            cycle_done = 1'b1;
            tick(1);
            cycle_done = 1'b0;
            wait_active(exp);
            chk16(latched_ctrl, prev);
            fl = (c < 4) ? 8'h01 : (c < 8) ? 8'h02 : (c < 12) ? (8'h04 << (c - 8)) :
                 (c == 15) ? 8'h40 : 8'h80;
            chk16({8'h00, mode_flags}, {8'h00, fl});
            if (c < 8)
                chk16({14'h0000, rate_sel}, {14'h0000, c[1:0]});
        end
        chk16({15'h0000, range_reserved}, 16'h0000);
        $display("test modes finished");
    endtask

    task automatic t_pins();
        pending_ctrl = 16'h4700;
        snap();
        tick(2);
        chk16(active_ctrl & csl_pkg::CTRL_IMPL, 16'h4700);
        pin_a_i = 1'b1;
        tick(6);
        chk16({14'h0000, rate_sel}, {14'h0000, csl_pkg::RATE_8SPS});
        pin_a_i = 1'b0;
        tick(6);
        chk16({14'h0000, rate_sel}, 16'h0000);
        pending_ctrl = 16'h4900;
        snap();
        tick(2);
        reg_access(1'b1, csl_pkg::GPIO_DATA_OFS, 16'h0002);
        chk16({14'h0000, pin_b_oe, pin_b_o}, 16'h0003);
        pin_a_i = 1'b1;
        tick(6);
        reg_access(1'b0, csl_pkg::GPIO_DATA_OFS, 16'h0000);
        chk16(rd, 16'h0003);
        pending_ctrl = 16'h4000;
        snap();
        tick(2);
        alert_a = 1'b1;
        alert_b = 1'b1;
        tick(1);
        chk16({12'h000, pin_a_oe, pin_a_o, pin_b_oe, pin_b_o}, 16'h000a);
        // A second command during a rate wait, at the cycle end, must still load.
        pending_ctrl = 16'h5000;
        snap();
        tick(1);
        pending_ctrl = 16'h4100;
        cycle_done = 1'b1;
        snap();
        cycle_done = 1'b0;
        chk16(latched_ctrl, 16'h4000);
        wait_active(16'h4100);
        $display("test pins finished");
    endtask

    // Reset for eight cycles, then run each scenario in turn.
    initial
    begin
        rst = 1'b1;
        {reg_rd, reg_wr, snapshot, cycle_done, alert_a, alert_b, pin_a_i, pin_b_i} = 8'h00;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        pending_ctrl = csl_pkg::CTRL_RESET;
        pending_range = 16'h0000;
        repeat (8) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        t_reset();
        t_ro_writes();
        t_snapshot();
        t_modes();
        t_pins();
        print_verdict();
    end
endmodule
